/* src/slow_timebase_pkg.sv */
// constants, register map and field layout of the slow time base and timer outputs
// What this block does
// - time base sets its flag every 32768>>rate slow clock cycles.
// - time base counts only slow clock cycles, internal or crystal source.
// - entering the time base service routine clears its flag.
// - writing 0 clears a flag bit in the flag register; 1 leaves it.
// - writing 1 to the clear bit resets the time base; bit self-clears.
// - counter mode input is the count pin, or slow clock over 16.
// - second timer wave output toggles on each overflow, dividing by two.
// - first timer wave output divides its overflows by 64.
// - second timer wave enable drives the pin; disabled otherwise.
// - first timer wave enable drives the pin; disabled otherwise.
// - reload value is two read/write bytes, reset to zero.
// - current count is two read/write bytes, reset to zero.
// - timer mode counts every 2 system clocks; counter mode on falling edges.
// - overflow sets the overflow flag unless used as serial clock.
`default_nettype none
package slow_timebase_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h95;
  localparam logic [7:0] ADDR_PIN_MODE = 8'hA6;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LO = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HI = 8'hCD;
  localparam logic [7:0] ADDR_TB_CFG = 8'hEF;
  localparam logic [7:0] ADDR_MISC = 8'hF8;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'hD8;
  localparam logic [7:0] ADDR_EVT_MASK = 8'hD9;
  localparam logic [7:0] PIN_MODE_RESET = 8'h0E;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] TB_CFG_RW_MASK = 8'h3D;
  localparam int TB_FLAG_BIT = 0;
  localparam int PIN_T2_WAVE_OUT_ENABLE_BIT = 4;
  localparam int PIN_T0_WAVE_OUT_ENABLE_BIT = 0;
  localparam int MISC_TB_CLEAR_BIT = 6;
  localparam int MISC_T2_COUNT_INPUT_SELECT_BIT = 2;
  localparam int TB_RATE_LSB = 3;
  localparam int TB_RATE_MSB = 5;
  localparam int TB_CNT_W = 15;
  localparam logic [15:0] TB_BASE_CYCLES = 16'h8000;
  localparam int SLOW_DIV_W = 4;
  localparam logic [3:0] SLOW_DIV_LAST = 4'hF;
  localparam int T0_DIV_W = 6;
  localparam logic [0:0] T2_PRE_LAST = 1'h1;
  localparam logic [15:0] T2_COUNT_MAX = 16'hFFFF;
  localparam int EVT_W = 2;
  localparam int EVT_TB = 0;
  localparam int EVT_T2 = 1;
  typedef enum logic {TIMER_MODE, COUNTER_MODE} t2_mode_t;
endpackage
`default_nettype wire

/* src/slow_timebase_timer_outputs.sv */
// slow time base, second timer count/reload registers and buzzer wave outputs
//
// Chosen here: the strobed register port.
`default_nettype none
module slow_timebase_timer_outputs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [slow_timebase_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [slow_timebase_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [slow_timebase_pkg::DATA_W-1:0] reg_rdata,
  input wire logic slow_clk_pin,
  input wire logic t2_pin_in,
  input wire logic t2_run,
  input wire slow_timebase_pkg::t2_mode_t t2_counter_timer_select,
  input wire logic t2_uart_clock_use,
  input wire logic t2_flag_clear,
  input wire logic t0_overflow,
  input wire logic timebase_isr_enter,
  output logic t2_pin_out,
  output logic t2_pin_oe,
  output logic t0_pin_out,
  output logic t0_pin_oe,
  output logic timebase_irq_flag,
  output logic t2_overflow_flag,
  output logic t2_overflow,
  output logic irq
);
  import slow_timebase_pkg::*;

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] want);
    wr_hit = wr && (a == want);
  endfunction

  function automatic logic [TB_CNT_W-1:0] tb_mask(input logic [2:0] rate);
    logic [15:0] span;
    span = (TB_BASE_CYCLES >> rate) - 16'h0001;
    tb_mask = span[TB_CNT_W-1:0];
  endfunction

  // ==========================================================
  // registers
  logic [7:0] pin_output_mode_control;
  logic [7:0] timebase_rate_and_ref_config;
  logic [7:0] misc_clear_and_select_control;
  logic [7:0] t2_reload_value_low;
  logic [7:0] t2_reload_value_high;
  logic [15:0] t2_count;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic [2:0] timebase_rate_select;
  logic t2_count_input_select;
  logic wr_misc;
  logic timebase_clear;

  assign timebase_rate_select = timebase_rate_and_ref_config[TB_RATE_MSB:TB_RATE_LSB];
  assign t2_count_input_select = misc_clear_and_select_control[MISC_T2_COUNT_INPUT_SELECT_BIT];
  assign wr_misc = wr_hit(reg_wr, reg_addr, ADDR_MISC);
  assign timebase_clear = wr_misc && reg_wdata[MISC_TB_CLEAR_BIT];

  always_ff @(posedge core_clk)
  begin
    if (rst)
      pin_output_mode_control <= PIN_MODE_RESET;
    else if (wr_hit(reg_wr, reg_addr, ADDR_PIN_MODE))
      pin_output_mode_control <= reg_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      timebase_rate_and_ref_config <= BYTE_ZERO;
    else if (wr_hit(reg_wr, reg_addr, ADDR_TB_CFG))
      timebase_rate_and_ref_config <= reg_wdata & TB_CFG_RW_MASK;
  end

  // clear bit reads back 1 for one cycle after the write only
  always_ff @(posedge core_clk)
  begin
    if (rst)
      misc_clear_and_select_control <= BYTE_ZERO;
    else if (wr_misc)
      misc_clear_and_select_control <= reg_wdata;
    else
      misc_clear_and_select_control[MISC_TB_CLEAR_BIT] <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      t2_reload_value_low <= BYTE_ZERO;
      t2_reload_value_high <= BYTE_ZERO;
    end
    else
    begin
      if (wr_hit(reg_wr, reg_addr, ADDR_RELOAD_LO))
        t2_reload_value_low <= reg_wdata;
      if (wr_hit(reg_wr, reg_addr, ADDR_RELOAD_HI))
        t2_reload_value_high <= reg_wdata;
    end
  end

  // ==========================================================
  // synchronisers: stage a feeds stage b only
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic slow_prev;
  logic pin_prev;
  logic slow_rise;
  logic pin_fall;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      slow_prev <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      sync_a <= {t2_pin_in, slow_clk_pin};
      sync_b <= sync_a;
      slow_prev <= sync_b[0];
      pin_prev <= sync_b[1];
    end
  end

  assign slow_rise = sync_b[0] && !slow_prev;
  assign pin_fall = pin_prev && !sync_b[1];

  // slow clock over 16: its falling edge is the 15 -> 0 wrap
  logic [SLOW_DIV_W-1:0] slow_div;
  logic div16_fall;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      slow_div <= '0;
    else if (slow_rise)
      slow_div <= slow_div + 1'b1;
  end

  assign div16_fall = slow_rise && (slow_div == SLOW_DIV_LAST);

  // ==========================================================
  // time base
  logic [TB_CNT_W-1:0] tb_cnt;
  logic tb_tick;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      tb_cnt <= '0;
    else if (timebase_clear)
      tb_cnt <= '0;
    else if (slow_rise)
      tb_cnt <= tb_cnt + 1'b1;
  end

  assign tb_tick = slow_rise && !timebase_clear &&
    ((tb_cnt & tb_mask(timebase_rate_select)) == tb_mask(timebase_rate_select));

  // set wins over both kinds of clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
      timebase_irq_flag <= 1'b0;
    else if (tb_tick)
      timebase_irq_flag <= 1'b1;
    else if (timebase_isr_enter)
      timebase_irq_flag <= 1'b0;
    else if (wr_hit(reg_wr, reg_addr, ADDR_IRQ_FLAGS) && !reg_wdata[TB_FLAG_BIT])
      timebase_irq_flag <= 1'b0;
  end

  // ==========================================================
  // second timer
  logic [0:0] t2_pre;
  logic t2_evt;
  logic t2_ovf_evt;
  logic t2_flag_set;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      t2_pre <= '0;
    else if (t2_run && t2_counter_timer_select == TIMER_MODE)
      t2_pre <= t2_pre + 1'b1;
    else
      t2_pre <= '0;
  end

  always_comb
  begin
    t2_evt = 1'b0;
    case (t2_counter_timer_select)
      TIMER_MODE: t2_evt = t2_run && (t2_pre == T2_PRE_LAST);
      COUNTER_MODE: t2_evt = t2_run && (t2_count_input_select ? div16_fall : pin_fall);
      default: t2_evt = 1'b0;
    endcase
  end

  // a software write in the same cycle wins over counting
  assign t2_ovf_evt = t2_evt && (t2_count == T2_COUNT_MAX) &&
    !wr_hit(reg_wr, reg_addr, ADDR_COUNT_LO) && !wr_hit(reg_wr, reg_addr, ADDR_COUNT_HI);
  assign t2_flag_set = t2_ovf_evt && !t2_uart_clock_use;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      t2_count <= '0;
    else if (wr_hit(reg_wr, reg_addr, ADDR_COUNT_LO))
      t2_count[7:0] <= reg_wdata;
    else if (wr_hit(reg_wr, reg_addr, ADDR_COUNT_HI))
      t2_count[15:8] <= reg_wdata;
    else if (t2_ovf_evt)
      t2_count <= {t2_reload_value_high, t2_reload_value_low};
    else if (t2_evt)
      t2_count <= t2_count + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      t2_overflow_flag <= 1'b0;
    else if (t2_flag_set)
      t2_overflow_flag <= 1'b1;
    else if (t2_flag_clear)
      t2_overflow_flag <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      t2_overflow <= 1'b0;
    else
      t2_overflow <= t2_ovf_evt;
  end

  // ==========================================================
  // wave outputs
  logic [T0_DIV_W-1:0] t0_div;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      t2_pin_out <= 1'b0;
    else if (t2_ovf_evt)
      t2_pin_out <= !t2_pin_out;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      t0_div <= '0;
    else if (t0_overflow)
      t0_div <= t0_div + 1'b1;
  end

  assign t0_pin_out = t0_div[T0_DIV_W-1];
  assign t2_pin_oe = pin_output_mode_control[PIN_T2_WAVE_OUT_ENABLE_BIT];
  assign t0_pin_oe = pin_output_mode_control[PIN_T0_WAVE_OUT_ENABLE_BIT];

  // ==========================================================
  // event status, mask and interrupt
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;

  assign evt_set = {t2_flag_set, tb_tick};
  assign evt_clr = wr_hit(reg_wr, reg_addr, ADDR_EVT_STATUS) ? reg_wdata[EVT_W-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < EVT_W; gi++)
    begin : g_evt
      always_ff @(posedge core_clk)
      begin
        if (rst)
          evt_status[gi] <= 1'b0;
        else if (evt_set[gi])
          evt_status[gi] <= 1'b1;
        else if (evt_clr[gi])
          evt_status[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (rst)
      evt_mask <= '0;
    else if (wr_hit(reg_wr, reg_addr, ADDR_EVT_MASK))
      evt_mask <= reg_wdata[EVT_W-1:0];
  end

  assign irq = |(evt_status & evt_mask);

  // ==========================================================
  // read port: data only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (rst || !reg_rd)
      reg_rdata <= BYTE_ZERO;
    else
    begin
      case (reg_addr)
        ADDR_IRQ_FLAGS: reg_rdata <= {7'h00, timebase_irq_flag};
        ADDR_PIN_MODE: reg_rdata <= pin_output_mode_control;
        ADDR_RELOAD_LO: reg_rdata <= t2_reload_value_low;
        ADDR_RELOAD_HI: reg_rdata <= t2_reload_value_high;
        ADDR_COUNT_LO: reg_rdata <= t2_count[7:0];
        ADDR_COUNT_HI: reg_rdata <= t2_count[15:8];
        ADDR_TB_CFG: reg_rdata <= timebase_rate_and_ref_config;
        ADDR_MISC: reg_rdata <= misc_clear_and_select_control;
        ADDR_EVT_STATUS: reg_rdata <= {6'h00, evt_status};
        ADDR_EVT_MASK: reg_rdata <= {6'h00, evt_mask};
        default: reg_rdata <= BYTE_ZERO;
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_clear_write;
    wr_misc && reg_wdata[MISC_TB_CLEAR_BIT];
  endsequence

  sequence s_clear_done;
    (tb_cnt == '0) && misc_clear_and_select_control[MISC_TB_CLEAR_BIT] ##1
      !misc_clear_and_select_control[MISC_TB_CLEAR_BIT] || wr_misc;
  endsequence

  a_tb_flag_set: assert property (tb_tick |=> timebase_irq_flag)
    else $error("time base tick did not set flag");
  a_tb_slow_only: assert property (!slow_rise |=> $stable(timebase_irq_flag) || !timebase_irq_flag)
    else $error("time base flag rose without slow clock edge");
  a_tb_isr_clear: assert property (timebase_isr_enter && !tb_tick |=> !timebase_irq_flag)
    else $error("service entry did not clear flag");
  a_tb_write_one: assert property (wr_hit(reg_wr, reg_addr, ADDR_IRQ_FLAGS) && reg_wdata[TB_FLAG_BIT]
    && timebase_irq_flag && !timebase_isr_enter |=> timebase_irq_flag)
    else $error("writing one changed flag");
  a_tb_clear_bit: assert property (s_clear_write |=> s_clear_done)
    else $error("clear bit did not reset and self clear");
  a_t2_slow_div: assert property (t2_run && t2_counter_timer_select == COUNTER_MODE && t2_count_input_select
    && !div16_fall && !reg_wr |=> $stable(t2_count))
    else $error("counter advanced without slow clock over 16");
  a_t2_wave_div: assert property ($changed(t2_pin_out) |-> t2_overflow)
    else $error("second wave changed without overflow");
  a_t0_wave_div: assert property ($changed(t0_pin_out) |-> $past(t0_overflow) && $past(t0_div[4:0]) == 5'h1F)
    else $error("first wave changed off its 32nd overflow");
  a_t2_oe_follow: assert property (wr_hit(reg_wr, reg_addr, ADDR_PIN_MODE)
    |=> t2_pin_oe == $past(reg_wdata[PIN_T2_WAVE_OUT_ENABLE_BIT]) && t0_pin_oe == $past(reg_wdata[PIN_T0_WAVE_OUT_ENABLE_BIT]))
    else $error("wave enable did not follow write");
  a_t2_timer_rate: assert property (t2_evt && t2_counter_timer_select == TIMER_MODE |=> !t2_evt)
    else $error("timer mode counted on adjacent cycles");
  a_t2_uart_flag: assert property (t2_ovf_evt && t2_uart_clock_use && !t2_overflow_flag |=> !t2_overflow_flag)
    else $error("overflow flag set while serial clock");
  a_t2_reload: assert property (t2_ovf_evt |=> t2_count == $past({t2_reload_value_high, t2_reload_value_low}))
    else $error("overflow did not load reload value");
endmodule
`default_nettype wire

/* bench/slow_timebase_timer_outputs_tb_top.sv */
// self-checking testbench for the slow time base and timer wave outputs
`default_nettype none
module slow_timebase_timer_outputs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import slow_timebase_pkg::*;
  // ==========================================
  // signals and design instance
  logic core_clk = 0;
  logic rst = 1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [DATA_W-1:0] reg_rdata;
  logic slow_clk_pin = 0;
  logic t2_pin_in = 1;
  logic t2_run = 0;
  t2_mode_t t2_sel = TIMER_MODE;
  logic t2_uart_clock_use = 0;
  logic t2_flag_clear = 0;
  logic t0_overflow = 0;
  logic timebase_isr_enter = 0;
  logic t2_pin_out, t2_pin_oe, t0_pin_out, t0_pin_oe;
  logic timebase_irq_flag, t2_overflow_flag, t2_overflow, irq;
  int error_cnt = 0;
  int n_compared = 0;
  int ovf_cnt = 0;
  logic [7:0] d;
  slow_timebase_timer_outputs i_slow_timebase_timer_outputs (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slow_clk_pin(slow_clk_pin), .t2_pin_in(t2_pin_in),
    .t2_run(t2_run), .t2_counter_timer_select(t2_sel), .t2_uart_clock_use(t2_uart_clock_use),
    .t2_flag_clear(t2_flag_clear), .t0_overflow(t0_overflow), .timebase_isr_enter(timebase_isr_enter),
    .t2_pin_out(t2_pin_out), .t2_pin_oe(t2_pin_oe), .t0_pin_out(t0_pin_out), .t0_pin_oe(t0_pin_oe),
    .timebase_irq_flag(timebase_irq_flag), .t2_overflow_flag(t2_overflow_flag),
    .t2_overflow(t2_overflow), .irq(irq)
  );
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (t2_overflow === 1'b1)
      ovf_cnt++;
  end
  // ==========================================
  // compare, bus and stimulus tasks
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  // slow clock runs only while asked, 8 core cycles per period
  task automatic slow_cycles(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge core_clk);
      slow_clk_pin <= 1;
      repeat (4) @(posedge core_clk);
      slow_clk_pin <= 0;
    end
  endtask
  // which same-clock input: 0 service entry, 1 overflow flag clear, 2 count pin, else first timer overflow
  task automatic drive_pulse(input int k, input logic v);
    case (k)
      0: timebase_isr_enter <= v;
      1: t2_flag_clear <= v;
      2: t2_pin_in <= v;
      default: t0_overflow <= v;
    endcase
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    drive_pulse(k, 1'b1);
    @(posedge core_clk);
    drive_pulse(k, 1'b0);
  endtask
  task automatic load_count(input logic [7:0] hi, input logic [7:0] lo);
    wr(ADDR_COUNT_LO, lo);
    wr(ADDR_COUNT_HI, hi);
  endtask
  task automatic wait_ovf(input int from, input int limit);
    for (int i = 0; i < limit && ovf_cnt == from; i++)
      @(posedge core_clk);
    #1 check_bit(ovf_cnt == from + 1, 1'b1, "one overflow expected");
  endtask
  // ==========================================
  // scenarios
  task automatic test_reset_map;
    logic [7:0] adr [7] = '{ADDR_PIN_MODE, ADDR_RELOAD_LO, ADDR_RELOAD_HI, ADDR_COUNT_LO, ADDR_COUNT_HI,
      ADDR_MISC, 8'h50};
    logic [7:0] exp [7] = '{8'h0E, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      rd(adr[i], d);
      check_byte(d, exp[i], "reset value");
    end
    for (int i = 1; i < 5; i++)
    begin
      wr(adr[i], 8'hA5 ^ 8'(i));
      rd(adr[i], d);
      check_byte(d, 8'hA5 ^ 8'(i), "byte read back");
    end
    wr(8'h50, 8'hFF);
    rd(8'h50, d);
    check_byte(d, 8'h00, "unmapped read");
    check_bit(t2_pin_oe | t0_pin_oe, 1'b0, "outputs disabled after reset");
    $display("test reset_map done");
  endtask
  task automatic run_tb_interval(input logic [2:0] code);
    int n;
    n = 32'h8000 >> code;
    wr(ADDR_TB_CFG, {2'b00, code, 3'b000});
    rd(ADDR_TB_CFG, d);
    check_byte(d, {2'b00, code, 3'b000}, "rate field read back");
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= ADDR_MISC;
    reg_wdata <= 8'h40;
    @(posedge core_clk);
    reg_wr <= 0;
    reg_rd <= 1;
    @(posedge core_clk);
    #1 check_byte(reg_rdata, 8'h40, "clear bit reads one");
    @(posedge core_clk);
    reg_rd <= 0;
    #1 check_byte(reg_rdata, 8'h00, "clear bit self clears");
    wr(ADDR_IRQ_FLAGS, 8'hFE);
    slow_cycles(n - 1);
    repeat (6) @(posedge core_clk);
    check_bit(timebase_irq_flag, 1'b0, "flag early");
    slow_cycles(1);
    check_bit(timebase_irq_flag, 1'b1, "flag at interval");
  endtask
  task automatic test_timebase;
    run_tb_interval(3'd7);
    pulse(0);
    #1 check_bit(timebase_irq_flag, 1'b0, "service entry clears");
    run_tb_interval(3'd6);
    wr(ADDR_IRQ_FLAGS, 8'hFF);
    rd(ADDR_IRQ_FLAGS, d);
    check_byte(d, 8'h01, "write one keeps flag");
    wr(ADDR_IRQ_FLAGS, 8'hFE);
    rd(ADDR_IRQ_FLAGS, d);
    check_byte(d, 8'h00, "write FE clears flag");
    $display("test timebase done");
  endtask
  task automatic test_t2_timer;
    int c;
    wr(ADDR_RELOAD_LO, 8'h34);
    wr(ADDR_RELOAD_HI, 8'h12);
    wr(ADDR_PIN_MODE, 8'h1E);
    load_count(8'hFF, 8'hF0);
    c = ovf_cnt;
    t2_sel <= TIMER_MODE;
    t2_run <= 1;
    repeat (29) @(posedge core_clk);
    #1 check_bit(ovf_cnt == c, 1'b1, "timer mode too fast");
    wait_ovf(c, 8);
    t2_run <= 0;
    check_bit(t2_overflow_flag, 1'b1, "overflow flag");
    check_bit(t2_pin_out, 1'b1, "wave toggled");
    check_bit(t2_pin_oe, 1'b1, "wave enabled");
    rd(ADDR_COUNT_HI, d);
    check_byte(d, 8'h12, "reload on overflow");
    pulse(1);
    #1 check_bit(t2_overflow_flag, 1'b0, "software clear");
    t2_uart_clock_use <= 1;
    load_count(8'hFF, 8'hFE);
    c = ovf_cnt;
    t2_run <= 1;
    wait_ovf(c, 20);
    t2_run <= 0;
    t2_uart_clock_use <= 0;
    check_bit(t2_overflow_flag, 1'b0, "serial clock use no flag");
    check_bit(t2_pin_out, 1'b0, "wave divides by two");
    wr(ADDR_PIN_MODE, 8'h0E);
    #1 check_bit(t2_pin_oe, 1'b0, "wave disabled");
    $display("test t2_timer done");
  endtask
  task automatic test_t2_counter;
    int c;
    wr(ADDR_MISC, 8'h00);
    load_count(8'hFF, 8'hFF);
    c = ovf_cnt;
    t2_sel <= COUNTER_MODE;
    t2_run <= 1;
    repeat (20) @(posedge core_clk);
    t2_pin_in <= 0;
    #1 check_bit(ovf_cnt == c, 1'b1, "no count without pin edge");
    wait_ovf(c, 10);
    t2_pin_in <= 1;
    wr(ADDR_MISC, 8'h04);
    load_count(8'hFF, 8'hFF);
    c = ovf_cnt;
    repeat (3)
    begin
      pulse(2);
      repeat (4) @(posedge core_clk);
    end
    check_bit(ovf_cnt == c, 1'b1, "pin ignored on slow select");
    slow_cycles(17);
    check_bit(ovf_cnt == c + 1, 1'b1, "slow over 16 counts");
    t2_run <= 0;
    $display("test t2_counter done");
  endtask
  task automatic test_t0_wave;
    wr(ADDR_PIN_MODE, 8'h0F);
    #1 check_bit(t0_pin_oe, 1'b1, "t0 wave enabled");
    repeat (31) pulse(3);
    #1 check_bit(t0_pin_out, 1'b0, "t0 wave early");
    pulse(3);
    @(posedge core_clk);
    #1 check_bit(t0_pin_out, 1'b1, "t0 wave half period");
    repeat (32) pulse(3);
    @(posedge core_clk);
    #1 check_bit(t0_pin_out, 1'b0, "t0 wave full period");
    wr(ADDR_PIN_MODE, 8'h0E);
    #1 check_bit(t0_pin_oe, 1'b0, "t0 wave disabled");
    $display("test t0_wave done");
  endtask
  task automatic test_irq;
    check_bit(irq, 1'b0, "masked events");
    wr(ADDR_EVT_MASK, 8'h03);
    rd(ADDR_EVT_STATUS, d);
    check_byte(d, 8'h03, "sticky status");
    check_bit(irq, 1'b1, "unmasked event");
    wr(ADDR_EVT_STATUS, 8'h01);
    #1 check_bit(irq, 1'b1, "one bit left");
    wr(ADDR_EVT_STATUS, 8'h02);
    #1 check_bit(irq, 1'b0, "all cleared");
    $display("test irq done");
  endtask
  // ==========================================
  // run control
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #400us;
    error_cnt++;
    $display("BAD t=%0t watchdog expired", $time);
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 0;
    test_reset_map();
    test_timebase();
    test_t2_timer();
    test_t2_counter();
    test_t0_wave();
    test_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
